// File: rtl/cpl_top.sv
module cpl_top import cpl_pkg::*; #(
   parameter logic [31:0] P_EXPO_RST = 32'(CPL_EXPO_MIN_US * CPL_CLK_MHZ)
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [3:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // pixel stream in
   input wire logic i_pix_valid,
   input wire logic [CPL_WORD_W-1:0] i_pix_word,
   output logic o_pix_ready,
   // link side
   input wire logic i_link_clk,
   output logic [CPL_TX_W-1:0] o_tx_word,
   // serial control lines
   input wire logic [1:0] i_rear_switch_bank,
   input wire logic i_ser_tc,
   output logic o_ser_tc_rx,
   input wire logic i_ser_tfg_tx,
   output logic o_ser_tfg,
   output logic o_ser_tfg_oe,
   // timing pins
   input wire logic i_trig_in,
   output logic o_integ_out,
   output logic o_integ_oe,
   output logic o_readout_start
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      logic ext;
      logic pol;
      logic [1:0] mode;
      logic [31:0] expo;
      logic lclk_prev;
      logic trig_prev;
      cpl_state_type st;
      logic [31:0] cnt;
      logic pend;
      logic armed;
      logic [CPL_TX_W-1:0] tx;
      logic lval;
      logic fval;
      logic tfg;
      logic tfg_oe;
      logic tc_rx;
      logic integ;
      logic rd_pulse;
      logic [15:0] rd_count;
   } cpl_top_type;
   cpl_top_type q;
   cpl_top_type d;
   logic [CPL_SYNC_W-1:0] sy_in;
   logic [CPL_SYNC_W-1:0] sy;
   logic bus_wr;
   logic lclk_rise;
   logic trig_act;
   logic trig_rise;
   logic trig_fall;
   logic ser_en;
   logic [1:0] new_mode;
   logic new_ext;
   cpl_stream_if #(.W(CPL_WORD_W)) in_if ();
   cpl_stream_if #(.W(CPL_WORD_W)) out_if ();
   // ----------------------------------------
   // pin synchronisers and buffer
   // ----------------------------------------
   assign sy_in = {i_ser_tc, i_rear_switch_bank, i_trig_in, i_link_clk};
   cpl_sync3 #(.W(CPL_SYNC_W)) u_sync (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_async(sy_in),
      .o_level(sy)
   );
   assign in_if.valid = i_pix_valid;
   assign in_if.data = i_pix_word;
   assign o_pix_ready = in_if.ready;
   cpl_buf2 u_buf (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .s_in(in_if.snk),
      .s_out(out_if.src)
   );
   // the buffer drains one word per link clock; an empty slot sends a blank word
   assign lclk_rise = sy[CPL_SY_LCLK] && !q.lclk_prev;
   assign out_if.ready = lclk_rise;
   // ----------------------------------------
   // link word packing
   // ----------------------------------------
   function automatic logic [CPL_TX_W-1:0] cpl_pack(
      input logic [CPL_PIX_W-1:0] pix,
      input logic dval,
      input logic lval,
      input logic fval
   );
      logic [CPL_TX_W-1:0] w;
      w = '0;
      w[4:0] = pix[4:0];
      w[6] = pix[5];
      w[27] = pix[6];
      w[5] = pix[7];
      w[9:7] = pix[10:8];
      w[14:12] = pix[13:11];
      w[CPL_TX_DVAL] = dval;
      w[CPL_TX_LVAL] = lval;
      w[CPL_TX_FVAL] = fval;
      return w;
   endfunction
   // ----------------------------------------
   // next state
   // ----------------------------------------
   assign bus_wr = i_wb_cyc && i_wb_stb && i_wb_we && q.ack && (i_wb_adr == CPL_ADR_CTRL);
   assign new_ext = i_wb_sel[0] ? i_wb_dat[CPL_CTRL_EXT] : q.ext;
   assign new_mode = i_wb_sel[0] ? i_wb_dat[CPL_CTRL_MODE+:2] : q.mode;
   assign trig_act = q.pol ? sy[CPL_SY_TRIG] : !sy[CPL_SY_TRIG];
   assign trig_rise = q.ext && trig_act && !q.trig_prev;
   assign trig_fall = q.ext && !trig_act && q.trig_prev;
   // position two on blocks the serial lines
   assign ser_en = !sy[CPL_SY_SW1];
   always_comb
   begin
      d = q;
      d.rd_pulse = 1'b0;
      // classic wishbone: one-cycle ack, dropped the cycle after
      d.ack = i_wb_cyc && i_wb_stb && !q.ack;
      if (i_wb_cyc && i_wb_stb && !q.ack)
      begin
         unique case (i_wb_adr)
            CPL_ADR_CTRL: d.rdat = {28'h0000000, q.mode, q.pol, q.ext};
            CPL_ADR_EXPO: d.rdat = q.expo;
            CPL_ADR_STAT: d.rdat = {q.rd_count, 10'h000, sy[CPL_SY_SW1:CPL_SY_SW0],
                                    q.armed, q.pend, q.st};
            default: d.rdat = 32'h00000000;
         endcase
      end
      if (i_wb_cyc && i_wb_stb && i_wb_we && q.ack && (i_wb_adr == CPL_ADR_EXPO))
      begin
         for (int b = 0; b < 4; b++)
         begin
            if (i_wb_sel[b])
               d.expo[8*b+:8] = i_wb_dat[8*b+:8];
         end
      end
      // link word, refreshed only on a link clock edge
      d.lclk_prev = sy[CPL_SY_LCLK];
      if (lclk_rise)
      begin
         if (out_if.valid)
         begin
            d.lval = out_if.data[CPL_W_LVAL];
            d.fval = out_if.data[CPL_W_FVAL];
            d.tx = cpl_pack(out_if.data[CPL_PIX_W-1:0], out_if.data[CPL_W_DVAL],
                            out_if.data[CPL_W_LVAL], out_if.data[CPL_W_FVAL]);
         end
         else
            d.tx = cpl_pack(14'h0000, 1'b0,
                            q.lval, q.fval);
      end
      // serial control, idle high while blocked
      d.tfg = ser_en ? i_ser_tfg_tx : 1'b1;
      d.tfg_oe = ser_en;
      d.tc_rx = ser_en ? sy[CPL_SY_TC] : 1'b1;
      // exposure sequencing
      d.trig_prev = trig_act;
      unique case (q.st)
         CPL_ST_IDLE:
         begin
            if (!q.ext)
            begin
               d.st = CPL_ST_EXPOSE;
               d.cnt = q.expo;
            end
            else if (trig_rise && (q.mode == CPL_TM_SYNC))
            begin
               // first pulse only arms; exposure spans pulse to pulse
               d.armed = 1'b1;
               d.st = CPL_ST_EXPOSE;
            end
            else if (trig_rise)
            begin
               d.st = CPL_ST_EXPOSE;
               d.cnt = q.expo;
            end
         end
         CPL_ST_EXPOSE:
         begin
            if (q.ext && (q.mode == CPL_TM_SYNC))
            begin
               if (trig_rise)
               begin
                  d.st = CPL_ST_READ;
                  d.cnt = CPL_READOUT_CYC;
                  d.rd_pulse = 1'b1;
               end
            end
            else if (q.ext && (q.mode == CPL_TM_LEVEL))
            begin
               if (trig_fall)
               begin
                  d.st = CPL_ST_READ;
                  d.cnt = CPL_READOUT_CYC;
                  d.rd_pulse = 1'b1;
               end
            end
            else
            begin
               if (trig_rise)
                  d.pend = 1'b1;
               if (q.cnt <= 32'h00000001)
               begin
                  d.st = CPL_ST_READ;
                  d.cnt = CPL_READOUT_CYC;
                  d.rd_pulse = 1'b1;
               end
               else
                  d.cnt = q.cnt - 32'h00000001;
            end
         end
         CPL_ST_READ:
         begin
            if (trig_rise && !(q.mode == CPL_TM_SYNC))
               d.pend = 1'b1;
            if (q.cnt <= 32'h00000001)
            begin
               if (!q.ext || (q.mode == CPL_TM_SYNC) || q.pend || d.pend)
               begin
                  // a trigger seen during readout runs the next cycle at once
                  d.st = CPL_ST_EXPOSE;
                  d.cnt = q.expo;
                  d.pend = 1'b0;
               end
               else
                  d.st = CPL_ST_IDLE;
            end
            else
               d.cnt = q.cnt - 32'h00000001;
         end
         default:
            d.st = CPL_ST_IDLE;
      endcase
      if (d.rd_pulse)
         d.rd_count = q.rd_count + 16'h0001;
      // a control write that changes ext or mode restarts sequencing, so sync mode needs a fresh first pulse
      if (bus_wr)
      begin
         if (i_wb_sel[0])
            d.pol = i_wb_dat[CPL_CTRL_POL];
         d.ext = new_ext;
         d.mode = new_mode;
         if ((new_ext != q.ext) || (new_mode != q.mode))
         begin
            d.st = CPL_ST_IDLE;
            d.armed = 1'b0;
            d.pend = 1'b0;
            d.rd_pulse = 1'b0;
         end
      end
      if (!d.ext)
         d.pend = 1'b0;
      d.integ = (d.st == CPL_ST_EXPOSE) && !d.ext;
   end
   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         q <= '0;
         q.ext <= CPL_EXT_RST;
         q.pol <= CPL_POL_RST;
         q.mode <= CPL_MODE_RST;
         q.expo <= P_EXPO_RST;
         q.st <= CPL_ST_IDLE;
         q.tfg <= 1'b1;
         q.tc_rx <= 1'b1;
      end
      else
         q <= d;
   end
   assign o_wb_ack = q.ack;
   assign o_wb_dat = q.rdat;
   assign o_tx_word = q.tx;
   assign o_ser_tfg = q.tfg;
   assign o_ser_tfg_oe = q.tfg_oe;
   assign o_ser_tc_rx = q.tc_rx;
   assign o_integ_out = q.integ;
   assign o_integ_oe = !q.ext;
   assign o_readout_start = q.rd_pulse;
   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rstn);
   AST_ACK_ONE: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack held longer than one cycle");
   AST_ACK_CAUSE: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
      else $error("ack without a request");
   AST_TX_STEADY: assert property (!$past(lclk_rise) |-> $stable(o_tx_word))
      else $error("link word changed between link clock edges");
   AST_TX_ZERO: assert property ((o_tx_word[11:10] == 2'h0) && (o_tx_word[23:15] == 9'h000))
      else $error("unused link bit is not zero");
   AST_DVAL_BLANK: assert property (lclk_rise && !out_if.valid
      |=> !o_tx_word[CPL_TX_DVAL])
      else $error("data valid set on a blank word");
   AST_PIX_MAP: assert property (lclk_rise && out_if.valid |=>
      (o_tx_word[27] == $past(out_if.data[6])) && (o_tx_word[5] == $past(out_if.data[7]))
      && (o_tx_word[14] == $past(out_if.data[13])))
      else $error("pixel bit placed on the wrong link bit");
   AST_LINE_FRAME: assert property (lclk_rise && out_if.valid |=>
      (o_tx_word[CPL_TX_LVAL] == $past(out_if.data[CPL_W_LVAL]))
      && (o_tx_word[CPL_TX_FVAL] == $past(out_if.data[CPL_W_FVAL])))
      else $error("line or frame valid lost its word");
   AST_SER_BLOCK: assert property ($past(sy[CPL_SY_SW1]) |-> !o_ser_tfg_oe && o_ser_tc_rx)
      else $error("serial control active with switch two on");
   AST_NO_INT_TRIG: assert property (!q.ext && !$past(q.ext) |-> !q.pend && !q.armed)
      else $error("trigger taken in internal mode");
   AST_EDGE_START: assert property (q.ext && (q.mode == CPL_TM_EDGE)
      && (q.st == CPL_ST_IDLE) && trig_rise && !bus_wr
      |=> (q.st == CPL_ST_EXPOSE) && (q.cnt == $past(q.expo)))
      else $error("edge did not start an exposure");
   AST_SYNC_FIRST: assert property (q.ext && (q.mode == CPL_TM_SYNC)
      && !q.armed && trig_rise && !bus_wr |=> !o_readout_start && q.armed)
      else $error("first sync pulse started a readout");
   AST_INTEG_EXT: assert property (q.ext |-> !o_integ_oe && !o_integ_out)
      else $error("integration output driven in external mode");
endmodule

// File: pkg/cpl_pkg.sv
package cpl_pkg;
   // ----------------------------------------
   // link word layout
   // ----------------------------------------
   localparam int CPL_PIX_W = 14;
   localparam int CPL_TX_W = 28;
   localparam int CPL_TX_LVAL = 24;
   localparam int CPL_TX_FVAL = 25;
   localparam int CPL_TX_DVAL = 26;
   // stream word: pixel, then data, line and frame valid
   localparam int CPL_WORD_W = 17;
   localparam int CPL_W_DVAL = 14;
   localparam int CPL_W_LVAL = 15;
   localparam int CPL_W_FVAL = 16;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [3:0] CPL_ADR_CTRL = 4'h0;
   localparam logic [3:0] CPL_ADR_EXPO = 4'h4;
   localparam logic [3:0] CPL_ADR_STAT = 4'h8;
   localparam int CPL_CTRL_EXT = 0;
   localparam int CPL_CTRL_POL = 1;
   localparam int CPL_CTRL_MODE = 2;
   localparam logic [1:0] CPL_TM_EDGE = 2'h0;
   localparam logic [1:0] CPL_TM_LEVEL = 2'h1;
   localparam logic [1:0] CPL_TM_SYNC = 2'h2;
   localparam logic CPL_EXT_RST = 1'h0;
   localparam logic CPL_POL_RST = 1'h0;
   localparam logic [1:0] CPL_MODE_RST = 2'h0;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CPL_CLK_MHZ = 50;
   localparam int CPL_EXPO_MIN_US = 100;
   localparam logic [31:0] CPL_READOUT_CYC = 32'h00000010;
   // ----------------------------------------
   // synchroniser lanes
   // ----------------------------------------
   localparam int CPL_SYNC_W = 5;
   localparam int CPL_SY_LCLK = 0;
   localparam int CPL_SY_TRIG = 1;
   localparam int CPL_SY_SW0 = 2;
   localparam int CPL_SY_SW1 = 3;
   localparam int CPL_SY_TC = 4;
   typedef enum logic [1:0] {
      CPL_ST_IDLE = 2'b00,
      CPL_ST_EXPOSE = 2'b01,
      CPL_ST_READ = 2'b10
   } cpl_state_type;
endpackage

// File: pkg/cpl_stream_if.sv
interface cpl_stream_if #(parameter int W = 17);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// File: rtl/cpl_sync3.sv
module cpl_sync3 #(parameter int W = 1) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // asynchronous levels and their agreed copies
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_level
);
   typedef struct packed {
      logic [W-1:0] f1;
      logic [W-1:0] f2;
      logic [W-1:0] f3;
      logic [W-1:0] lvl;
   } cpl_sync_type;
   cpl_sync_type q;
   cpl_sync_type d;
   logic [W-1:0] lvl_nx;
   // a change counts only once stages two and three agree
   for (genvar g = 0; g < W; g++)
   begin : g_bit
      assign lvl_nx[g] = (q.f2[g] == q.f3[g]) ? q.f3[g] : q.lvl[g];
   end
   always_comb
   begin
      d = q;
      d.f1 = i_async;
      d.f2 = q.f1;
      d.f3 = q.f2;
      d.lvl = lvl_nx;
   end
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         q <= '0;
      else
         q <= d;
   end
   assign o_level = q.lvl;
endmodule

// File: rtl/cpl_buf2.sv
module cpl_buf2 import cpl_pkg::*; (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // filling side
   cpl_stream_if.snk s_in,
   // draining side
   cpl_stream_if.src s_out
);
   typedef struct packed {
      logic [1:0][CPL_WORD_W-1:0] mem;
      logic wr;
      logic rd;
      logic [1:0] cnt;
   } cpl_buf_type;
   cpl_buf_type q;
   cpl_buf_type d;
   logic push;
   logic pop;
   assign push = s_in.valid && s_in.ready;
   assign pop = s_out.valid && s_out.ready;
   always_comb
   begin
      d = q;
      if (push)
      begin
         d.mem[q.wr] = s_in.data;
         d.wr = ~q.wr;
      end
      if (pop)
         d.rd = ~q.rd;
      d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
   end
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         q <= '0;
      else
         q <= d;
   end
   // full stalls the source, so nothing is ever overwritten
   assign s_in.ready = (q.cnt != 2'h2);
   assign s_out.valid = (q.cnt != 2'h0);
   assign s_out.data = q.mem[q.rd];
endmodule

// File: verification/cpl_grabber_model.sv
module cpl_grabber_model import cpl_pkg::*; (
   // run control
   input wire logic i_run,
   // link
   input wire logic [CPL_TX_W-1:0] i_tx_word,
   output logic o_link_clk
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------
   // frame grabber side
   // ------------------------------
   logic [CPL_TX_W-1:0] words[$];
   initial
   begin
      o_link_clk = 1'b0;
      forever
      begin
         // clock stands still between frames
         wait (i_run === 1'b1);
         o_link_clk = 1'b1;
         #80;
         o_link_clk = 1'b0;
         #70;
         // late sample, word long settled
         if (i_tx_word[CPL_TX_DVAL] === 1'b1) words.push_back(i_tx_word);
         #10;
      end
   end
endmodule

// File: verification/cpl_top_tb.sv
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module cpl_top_tb import cpl_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------
   // signals
   // ------------------------------
   localparam logic [31:0] EXPO = 32'h00000014;
   logic i_clk, i_rstn, cyc, stb, we, pvalid, run, tc, tfg_tx, trig, act, on;
   logic [3:0] adr, sel;
   logic [31:0] wdat, r, rnd;
   logic [16:0] pword;
   logic [1:0] bank;
   logic [31:0] o_wb_dat;
   logic [27:0] o_tx_word;
   logic o_wb_ack, o_pix_ready, lclk, o_ser_tc_rx, o_ser_tfg, o_ser_tfg_oe;
   logic o_integ_out, o_integ_oe, o_readout_start;
   int fail_count, compares, rd_n;
   logic [16:0] sent[$];
   cpl_top #(.P_EXPO_RST(EXPO)) i_cpl_top (.i_clk(i_clk), .i_rstn(i_rstn), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
      .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_pix_valid(pvalid), .i_pix_word(pword),
      .o_pix_ready(o_pix_ready), .i_link_clk(lclk), .o_tx_word(o_tx_word),
      .i_rear_switch_bank(bank), .i_ser_tc(tc), .o_ser_tc_rx(o_ser_tc_rx),
      .i_ser_tfg_tx(tfg_tx), .o_ser_tfg(o_ser_tfg), .o_ser_tfg_oe(o_ser_tfg_oe),
      .i_trig_in(trig), .o_integ_out(o_integ_out), .o_integ_oe(o_integ_oe),
      .o_readout_start(o_readout_start));
   cpl_grabber_model i_cpl_grabber_model (.i_run(run), .i_tx_word(o_tx_word), .o_link_clk(lclk));
   initial
   begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end
   always @(posedge i_clk) if (o_readout_start === 1'b1) rd_n++;
   // ------------------------------
   // helpers
   // ------------------------------
   function automatic logic [27:0] exp_tx(input logic [16:0] w);
      logic [27:0] t;
      t = '0;
      t[4:0] = w[4:0];
      t[6] = w[5];
      t[27] = w[6];
      t[5] = w[7];
      t[9:7] = w[10:8];
      t[14:12] = w[13:11];
      t[26] = w[14];
      t[24] = w[15];
      t[25] = w[16];
      return t;
   endfunction
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge i_clk);
      while (o_wb_ack !== 1'b1 && n < 20)
      begin
         @(posedge i_clk);
         n++;
      end
      if (n == 20) fail_count++;
      // read data taken at the very edge that samples ack
      r = o_wb_dat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic push(input logic [16:0] w);
      int n;
      n = 0;
      @(posedge i_clk);
      pvalid <= 1'b1;
      pword <= w;
      @(posedge i_clk);
      while (o_pix_ready !== 1'b1 && n < 100)
      begin
         @(posedge i_clk);
         n++;
      end
      if (n == 100) fail_count++;
      pvalid <= 1'b0;
      // grabber keeps data-valid words only
      if (w[CPL_W_DVAL]) sent.push_back(w);
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      #1000000;
      fail_count++;
      summarize();
   end
   // ------------------------------
   // tests
   // ------------------------------
   initial
   begin
      {i_rstn, cyc, stb, we, pvalid, run, tc, tfg_tx, trig} = '0;
      {adr, wdat, pword, bank, fail_count, compares, rd_n} = '0;
      sel = 4'hF;
      void'($urandom(97550));
      repeat (16) @(posedge i_clk);
      i_rstn <= 1'b1;
      repeat (5) @(negedge i_clk);
      `CHK(o_integ_oe, 1'b1)
      `CHK(o_integ_out, 1'b1)
      wb(1'b0, CPL_ADR_CTRL, 32'h0);
      `CHK(r, 32'h0)
      wb(1'b0, CPL_ADR_EXPO, 32'h0);
      `CHK(r, EXPO)
      rnd = $urandom;
      wb(1'b1, 4'hC, rnd);
      wb(1'b0, 4'hC, 32'h0);
      `CHK(r, 32'h0)
      wb(1'b1, CPL_ADR_EXPO, rnd);
      wb(1'b0, CPL_ADR_EXPO, 32'h0);
      `CHK(r, rnd)
      wb(1'b1, CPL_ADR_EXPO, EXPO);
      $display("test regs done");
      for (int i = 0; i < 3; i++)
      begin
         @(posedge i_clk);
         bank <= 2'(i);
         tc <= 1'($urandom);
         tfg_tx <= 1'($urandom);
         repeat (10) @(negedge i_clk);
         on = ~bank[1];
         `CHK(o_ser_tfg_oe, on)
         `CHK(o_ser_tfg, on ? tfg_tx : 1'b1)
         `CHK(o_ser_tc_rx, on ? tc : 1'b1)
      end
      $display("test serial done");
      push(17'h13FFF);
      push(17'h04000);
      @(negedge i_clk);
      `CHK(o_pix_ready, 1'b0)
      run <= 1'b1;
      for (int i = 0; i < 4; i++) push({1'($urandom), 1'($urandom), 1'b1, 14'($urandom)});
      for (int n = 0; n < 400 && i_cpl_grabber_model.words.size() < 5; n++) @(posedge i_clk);
      repeat (40) @(posedge i_clk);
      run <= 1'b0;
      repeat (20) @(negedge i_clk);
      `CHK(i_cpl_grabber_model.words.size(), 5)
      for (int i = 0; i < i_cpl_grabber_model.words.size(); i++)
         `CHK(i_cpl_grabber_model.words[i], exp_tx(sent[i]))
      `CHK(o_tx_word, exp_tx({sent[4][16:15], 15'h0}))
      $display("test stream done");
      for (int m = 0; m < 4; m++)
      begin
         act = (m != 3);
         wb(1'b1, CPL_ADR_CTRL, (32'(m) << 2) | (32'(act) << 1));
         @(posedge i_clk) trig <= ~act;
         repeat (10) @(posedge i_clk);
         wb(1'b1, CPL_ADR_CTRL, (32'(m) << 2) | (32'(act) << 1) | 32'h1);
         repeat (10) @(negedge i_clk);
         `CHK(o_integ_oe, 1'b0)
         `CHK(o_integ_out, 1'b0)
         rd_n = 0;
         for (int p = 0; p < ((m == 2) ? 2 : 1); p++)
         begin
            @(posedge i_clk) trig <= act;
            repeat (20) @(posedge i_clk);
            `CHK(rd_n, (m == 2 && p == 1) ? 1 : 0)
            repeat ((m == 1) ? 4980 : 30) @(posedge i_clk);
            // pulse 1 us, or 100 us in level mode, far below the 1 ms time limit
            trig <= ~act;
            repeat (100) @(posedge i_clk);
         end
         `CHK(rd_n, 1)
      end
      $display("test trigger done");
      summarize();
   end
endmodule
